/* design/nvm_prog_port.v */
// Parallel programming port: command, address and data loading, page
// buffering, page programming towards the array, fuse and lock bytes, reads.
// Assumes all port inputs are synchronous to clk_sys and the array port is
// a simple synchronous memory with one cycle of read latency.
//
// What this block does
// - Action 10 and strobe load the command
// - Action 00, selects 00 load address low
// - Action 00, selects 01 load address high
// - Action 00, selects 10 load extended address
// - Action 01 loads data low or high
// - Page latch with select one pushes data at word address
// - Low bits word, upper bits page
// - Write low pulse programs page, busy shown
// - Command zero clears pending write state
// - EEPROM page loaded and programmed likewise
// - Flash read drives low or high byte
// - EEPROM read drives addressed byte
// - Fuse write picks byte by selects
// - Lock write programs zero bits only
// - Lock mode 3 blocks boot lock programming
// - Lock bits cleared only by erase
// - Fuse and lock read by selects
// - Signature byte read by low address
// - Calibration byte read with select one
// - Data bus driven only while enabled
// - Ready low while programming or while a latch waits for buffer room, high otherwise
// - Command and address held until reloaded
// - Action 11 does nothing
`timescale 1ns/1ps
`default_nettype none
`include "nvm_port_regs.vh"

module nvm_prog_port #(
  // Divides first, because the product of time and rate would overflow 32 bits.
  parameter PROG_CYCLES = `NVM_T_PROG_US * (1000000 / `NVM_CLK_PERIOD_PS),
  parameter PAGE_DEPTH = `NVM_PAGE_DEPTH,
  parameter [7:0] SIG_BYTE0 = 8'h5A, // Arbitrary identity value.
  parameter [7:0] SIG_BYTE1 = 8'hA5, // Arbitrary identity value.
  parameter [7:0] SIG_BYTE2 = 8'h3C, // Arbitrary identity value.
  parameter [7:0] CAL_BYTE = 8'h80
) (
  // Clock and reset.
  input wire clk_sys,
  input wire rst,
  // Programmer strobes and selects.
  input wire load_strobe,
  input wire page_latch,
  input wire write_n,
  input wire output_enable_n,
  input wire action_select_hi,
  input wire action_select_lo,
  input wire byte_select_1,
  input wire byte_select_2,
  // Data bus, split into its three signals.
  input wire [7:0] data_in,
  output wire [7:0] data_out,
  output wire data_oe,
  // Progress flag.
  output wire ready_busy,
  // Lock clear from the chip erase logic.
  input wire erase_locks,
  // Array write port.
  output wire nvm_wr_valid,
  input wire nvm_wr_ready,
  output wire nvm_wr_eeprom,
  output wire [23:0] nvm_wr_addr,
  output wire [15:0] nvm_wr_data,
  // Array read port.
  output wire nvm_rd_eeprom,
  output wire [23:0] nvm_rd_addr,
  input wire [15:0] nvm_rd_data
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_DRAIN = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;
  localparam [31:0] PROG_LAST = PROG_CYCLES - 1;

  // Picks one of four bytes by a two-bit select.
  function [7:0] pick4;
    input [1:0] sel;
    input [7:0] b0;
    input [7:0] b1;
    input [7:0] b2;
    input [7:0] b3;
    begin
      case (sel)
        2'b00: pick4 = b0;
        2'b01: pick4 = b1;
        2'b10: pick4 = b2;
        default: pick4 = b3;
      endcase
    end
  endfunction

  // Registers.
  reg strobe_prev_ff;
  reg latch_prev_ff;
  reg write_prev_ff;
  reg [7:0] cmd_ff;
  reg [23:0] addr_ff;
  reg [15:0] wdata_ff;
  reg pend_ff;
  reg [1:0] state_ff;
  reg [31:0] timer_ff;
  reg [7:0] fuse_lo_ff;
  reg [7:0] fuse_hi_ff;
  reg [7:0] fuse_ext_ff;
  reg [7:0] lock_ff;
  reg wr_valid_ff;
  reg [23:0] wr_addr_ff;
  reg [15:0] wr_data_ff;
  reg wr_ee_ff;
  reg rd_ee_ff;
  reg [23:0] rd_addr_ff;
  reg [7:0] dout_ff;
  reg doe_ff;
  reg rdy_ff;
  reg [7:0] nxt_dout;
  reg [7:0] nxt_lock;

  wire [1:0] act = {action_select_hi, action_select_lo};
  wire [1:0] bsel = {byte_select_2, byte_select_1};
  wire strobe_rise = load_strobe & ~strobe_prev_ff;
  wire latch_rise = page_latch & ~latch_prev_ff;
  wire write_fall = ~write_n & write_prev_ff;
  wire is_ee_wr = (cmd_ff == `NVM_CMD_WR_EE);
  wire is_page_cmd = (cmd_ff == `NVM_CMD_WR_FLASH) | is_ee_wr;
  wire idle = (state_ff == ST_IDLE);
  wire nop_load = strobe_rise && (act == `NVM_ACT_CMD) && (data_in == `NVM_CMD_NOP);

  // FIFO hookup.
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire [23:0] fifo_in_data;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [23:0] fifo_out_data;

  // ****************************************************************
  // Edge detection on the strobes
  // ****************************************************************

  // Strobes are sampled each cycle; edges act exactly once per pulse.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strobe_prev_ff <= 1'b0;
      latch_prev_ff <= 1'b0;
      write_prev_ff <= 1'b1;
    end else begin
      strobe_prev_ff <= load_strobe;
      latch_prev_ff <= page_latch;
      write_prev_ff <= write_n;
    end
  end

  // ****************************************************************
  // Command, address and data loading
  // ****************************************************************

  // Loads happen on the strobe's rising edge; values stay until reloaded.
  // held until reload
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_ff <= `NVM_CMD_NOP;
      addr_ff <= 24'h00_0000;
      wdata_ff <= 16'hFFFF;
    end else if (strobe_rise) begin
      case (act)
        `NVM_ACT_CMD: begin
          cmd_ff <= data_in;
        end
        `NVM_ACT_ADDR: begin
          case (bsel)
            `NVM_BS_LOW: addr_ff[7:0] <= data_in;
            `NVM_BS_HIGH: addr_ff[15:8] <= data_in;
            `NVM_BS_EXT: addr_ff[23:16] <= data_in;
            default: addr_ff <= addr_ff;
          endcase
        end
        `NVM_ACT_DATA: begin
          if (byte_select_1) begin
            wdata_ff[15:8] <= data_in;
          end else begin
            wdata_ff[7:0] <= data_in;
          end
        end
        default: cmd_ff <= cmd_ff;
      endcase
    end
  end

  // ****************************************************************
  // Page buffer
  // ****************************************************************

  // latch into buffer
  // A latch that meets a full buffer is held pending until the no-op command drops it,
  // since write pulses are ignored meanwhile; busy stays low so the programmer waits.
  assign fifo_in_valid = ((latch_rise & byte_select_1) | pend_ff) & idle;
  assign fifo_in_data = {addr_ff[7:0], wdata_ff};

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_ff <= 1'b0;
    end else if (nop_load) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= fifo_in_valid & ~fifo_in_ready;
    end
  end

  nvm_page_fifo #(
    .WIDTH(24),
    .DEPTH(PAGE_DEPTH),
    .AW(5)
  ) nvm_page_fifo_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(nop_load & idle),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign fifo_out_ready = (state_ff == ST_DRAIN) & (~wr_valid_ff | nvm_wr_ready);

  // ****************************************************************
  // Programming sequencer
  // ****************************************************************

  // Lock merge: bits can only go from 1 to 0 here; boot bits are frozen
  // once both basic bits are programmed.
  always @* begin
    nxt_lock = lock_ff & wdata_ff[7:0];
    if (lock_ff[`NVM_LOCK_BASIC_MSB:0] == 2'b00) begin
      nxt_lock[`NVM_LOCK_BOOT_MSB:`NVM_LOCK_BOOT_LSB] =
        lock_ff[`NVM_LOCK_BOOT_MSB:`NVM_LOCK_BOOT_LSB];
    end
  end

  // Write pulses are taken only when idle; during busy they are ignored.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      timer_ff <= 32'h0000_0000;
      fuse_lo_ff <= `NVM_FUSE_LO_RST;
      fuse_hi_ff <= `NVM_FUSE_HI_RST;
      fuse_ext_ff <= `NVM_FUSE_EXT_RST;
      lock_ff <= `NVM_LOCK_RST;
      wr_valid_ff <= 1'b0;
      wr_addr_ff <= 24'h00_0000;
      wr_data_ff <= 16'h0000;
      wr_ee_ff <= 1'b0;
    end else begin
      if (erase_locks) begin
        lock_ff <= `NVM_LOCK_RST;
      end
      case (state_ff)
        ST_IDLE: begin
          timer_ff <= 32'h0000_0000;
          if (write_fall && !pend_ff) begin
            if (is_page_cmd && bsel == `NVM_BS_LOW) begin
              state_ff <= ST_DRAIN;
              wr_ee_ff <= is_ee_wr;
            end else if (cmd_ff == `NVM_CMD_WR_FUSE) begin
              case (bsel)
                `NVM_BS_LOW: fuse_lo_ff <= wdata_ff[7:0];
                `NVM_BS_HIGH: fuse_hi_ff <= wdata_ff[7:0];
                `NVM_BS_EXT: fuse_ext_ff <= wdata_ff[7:0];
                default: fuse_lo_ff <= fuse_lo_ff;
              endcase
              state_ff <= ST_WAIT;
            end else if (cmd_ff == `NVM_CMD_WR_LOCK && !erase_locks) begin
              lock_ff <= nxt_lock;
              state_ff <= ST_WAIT;
            end
          end
        end
        ST_DRAIN: begin
          if (fifo_out_ready && fifo_out_valid) begin
            wr_valid_ff <= 1'b1;
            wr_data_ff <= fifo_out_data[15:0];
            if (wr_ee_ff) begin
              wr_addr_ff <= {8'h00, addr_ff[15:`NVM_EE_WORD_BITS],
                fifo_out_data[16 +: `NVM_EE_WORD_BITS]};
            end else begin
              wr_addr_ff <= {addr_ff[23:`NVM_FLASH_WORD_BITS],
                fifo_out_data[16 +: `NVM_FLASH_WORD_BITS]};
            end
          end else if (nvm_wr_ready) begin
            wr_valid_ff <= 1'b0;
          end
          if (!fifo_out_valid && (!wr_valid_ff || nvm_wr_ready)) begin
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // The cell programming time follows the transfer.
          if (timer_ff >= PROG_LAST) begin
            state_ff <= ST_IDLE;
          end else begin
            timer_ff <= timer_ff + 32'h0000_0001;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ready flag
  // Busy also covers a latch waiting for buffer room.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdy_ff <= 1'b1;
    end else begin
      rdy_ff <= idle & ~pend_ff & ~(write_fall & is_page_cmd & (bsel == `NVM_BS_LOW)) &
        ~(write_fall & (cmd_ff == `NVM_CMD_WR_FUSE)) &
        ~(write_fall & (cmd_ff == `NVM_CMD_WR_LOCK) & ~erase_locks);
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************

  // The array address follows the loaded address; data returns a cycle later.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_ee_ff <= 1'b0;
      rd_addr_ff <= 24'h00_0000;
    end else begin
      rd_ee_ff <= (cmd_ff == `NVM_CMD_RD_EE);
      rd_addr_ff <= (cmd_ff == `NVM_CMD_RD_EE) ? {8'h00, addr_ff[15:0]} : addr_ff;
    end
  end

  // Read data selection by command and byte selects.
  always @* begin
    case (cmd_ff)
      `NVM_CMD_RD_FLASH: nxt_dout = byte_select_1 ? nvm_rd_data[15:8] : nvm_rd_data[7:0];
      `NVM_CMD_RD_EE: nxt_dout = nvm_rd_data[7:0];
      `NVM_CMD_RD_FUSE: nxt_dout = pick4(bsel, fuse_lo_ff, lock_ff, fuse_ext_ff, fuse_hi_ff);
      `NVM_CMD_RD_SIG: begin
        if (byte_select_1) begin
          nxt_dout = CAL_BYTE;
        end else begin
          nxt_dout = pick4(addr_ff[1:0], SIG_BYTE0, SIG_BYTE1, SIG_BYTE2, 8'hFF);
          if (addr_ff[7:2] != 6'h00) begin
            nxt_dout = 8'hFF;
          end
        end
      end
      default: nxt_dout = 8'hFF;
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dout_ff <= 8'hFF;
      doe_ff <= 1'b0;
    end else begin
      dout_ff <= nxt_dout;
      doe_ff <= ~output_enable_n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  assign data_out = dout_ff;
  assign data_oe = doe_ff;
  assign ready_busy = rdy_ff;
  assign nvm_wr_valid = wr_valid_ff;
  assign nvm_wr_eeprom = wr_ee_ff;
  assign nvm_wr_addr = wr_addr_ff;
  assign nvm_wr_data = wr_data_ff;
  assign nvm_rd_eeprom = rd_ee_ff;
  assign nvm_rd_addr = rd_addr_ff;

endmodule

`default_nettype wire

/* pkg/nvm_port_regs.vh */
// Constants of the parallel programming port: command codes, action and
// byte-select encodings, page geometry, reset values and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef NVM_PORT_REGS_VH
`define NVM_PORT_REGS_VH

// Clock period of clk_sys in picoseconds (200 MHz).
`define NVM_CLK_PERIOD_PS 5000

// Action select encodings, {action_select_hi, action_select_lo}.
`define NVM_ACT_ADDR 2'b00
`define NVM_ACT_DATA 2'b01
`define NVM_ACT_CMD 2'b10
`define NVM_ACT_IDLE 2'b11

// Byte select encodings, {byte_select_2, byte_select_1}.
`define NVM_BS_LOW 2'b00
`define NVM_BS_HIGH 2'b01
`define NVM_BS_EXT 2'b10
`define NVM_BS_TOP 2'b11

// Command byte codes.
`define NVM_CMD_NOP 8'h00
`define NVM_CMD_WR_FUSE 8'h40
`define NVM_CMD_WR_LOCK 8'h20
`define NVM_CMD_WR_FLASH 8'h10
`define NVM_CMD_WR_EE 8'h11
`define NVM_CMD_RD_SIG 8'h08
`define NVM_CMD_RD_FUSE 8'h04
`define NVM_CMD_RD_FLASH 8'h02
`define NVM_CMD_RD_EE 8'h03

// Page geometry: word-in-page bits of flash and EEPROM, page buffer depth.
`define NVM_FLASH_WORD_BITS 7
`define NVM_EE_WORD_BITS 3
`define NVM_PAGE_DEPTH 32

// Lock byte fields: the two basic lock bits and the boot lock bits.
`define NVM_LOCK_BASIC_MSB 1
`define NVM_LOCK_BOOT_LSB 2
`define NVM_LOCK_BOOT_MSB 5

// Reset values of the fuse and lock bytes (all erased).
`define NVM_FUSE_LO_RST 8'hFF
`define NVM_FUSE_HI_RST 8'hFF
`define NVM_FUSE_EXT_RST 8'hFF
`define NVM_LOCK_RST 8'hFF

// Least write-to-ready time, in microseconds.
`define NVM_T_PROG_US 3700

`endif

/* design/nvm_page_fifo.v */
// Page buffer FIFO with parameterised width and depth.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module nvm_page_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset.
  input wire clk_sys,
  input wire rst,
  // Synchronous flush of all entries.
  input wire clear,
  // Filling side.
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side.
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;

  // Full and empty come from the occupancy count, never from pointers alone.
  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************

  // Storage is written without reset; only valid entries are ever read.
  always @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, so DEPTH need not be a power of two.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else if (clear) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* tb/nvm_prog_port_properties.sv */
// Checker for the programming port, watching only the top-level ports.
// Assumes one clock domain and the asynchronous active-high reset rst.
`timescale 1ns/1ps
`default_nettype none

module nvm_prog_port_props #(
  parameter PROG_CYCLES = 16
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Programmer side.
  input wire logic write_n,
  input wire logic output_enable_n,
  input wire logic data_oe,
  input wire logic ready_busy,
  // Array write port.
  input wire logic nvm_wr_valid,
  input wire logic nvm_wr_ready,
  input wire logic nvm_wr_eeprom,
  input wire logic [23:0] nvm_wr_addr,
  input wire logic [15:0] nvm_wr_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ********************************
  // Write-port steps
  // ********************************
  sequence wr_accept;
    nvm_wr_valid && nvm_wr_ready;
  endsequence
  sequence busy_hold;
    !ready_busy [*8];
  endsequence

  AST_OE_FOLLOW: assert property (!output_enable_n |=> data_oe)
    else $error("bus not driven after enable");
  AST_OE_RELEASE: assert property (output_enable_n |=> !data_oe)
    else $error("bus driven without enable");
  AST_RESET_IDLE: assert property ($fell(rst) |-> ready_busy && !nvm_wr_valid)
    else $error("not idle after reset");
  AST_WR_BUSY: assert property (nvm_wr_valid |-> !ready_busy)
    else $error("array write while ready");
  AST_WR_AFTER_BUSY: assert property ($rose(nvm_wr_valid) |-> !$past(ready_busy))
    else $error("array write before busy shown");
  AST_WR_HOLD: assert property (nvm_wr_valid && !nvm_wr_ready |=>
    nvm_wr_valid && $stable(nvm_wr_addr) && $stable(nvm_wr_data))
    else $error("array write dropped or changed");
  AST_PROG_WAIT: assert property (wr_accept |=> busy_hold)
    else $error("ready before programming wait");
  AST_BUSY_BOUNDED: assert property ($fell(ready_busy) |-> ##[1:1000] ready_busy)
    else $error("busy never ended");
  AST_EE_ADDR: assert property (nvm_wr_valid && nvm_wr_eeprom |->
    nvm_wr_addr[23:16] == 8'h00)
    else $error("eeprom address out of range");
endmodule
`default_nettype wire

/* tb/nvm_array_model.sv */
// Behavioural array behind the port: flash and EEPROM words, stalling writes.
// Assumes the port's array interface and one cycle of read latency.
`timescale 1ns/1ps
`default_nettype none

module nvm_array_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Write side.
  input wire logic nvm_wr_valid,
  output logic nvm_wr_ready,
  input wire logic nvm_wr_eeprom,
  input wire logic [23:0] nvm_wr_addr,
  input wire logic [15:0] nvm_wr_data,
  // Read side.
  input wire logic nvm_rd_eeprom,
  input wire logic [23:0] nvm_rd_addr,
  output logic [15:0] nvm_rd_data
);
  logic [15:0] fl [0:255];
  logic [15:0] ee [0:255];
  logic [23:0] last_addr;
  int wr_count;

  // Erased contents; only the low address byte indexes the small arrays.
  initial begin
    for (int i = 0; i < 256; i++) begin
      fl[i] = 16'hFFFF;
      ee[i] = 16'hFFFF;
    end
  end

  // Ready toggles every cycle, so a write waits at most one cycle before it is taken.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nvm_wr_ready <= 1'b0;
      wr_count <= 0;
      last_addr <= 24'h00_0000;
      nvm_rd_data <= 16'hFFFF;
    end else begin
      nvm_wr_ready <= ~nvm_wr_ready;
      if (nvm_wr_valid && nvm_wr_ready) begin
        if (nvm_wr_eeprom) begin
          ee[nvm_wr_addr[7:0]] <= nvm_wr_data;
        end else begin
          fl[nvm_wr_addr[7:0]] <= nvm_wr_data;
        end
        last_addr <= nvm_wr_addr;
        wr_count <= wr_count + 1;
      end
      nvm_rd_data <= nvm_rd_eeprom ? ee[nvm_rd_addr[7:0]] : fl[nvm_rd_addr[7:0]];
    end
  end
endmodule
`default_nettype wire

/* tb/nvm_prog_port_bench.sv */
// Self-checking bench: programmer tasks, flash, EEPROM, fuse, lock, reads.
// Assumes the array model as partner and a shortened programming wait.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_port_regs.vh"

module nvm_prog_port_bench;
  logic clk_sys = 0, rst = 1, load_strobe = 0, page_latch = 0, write_n = 1;
  logic output_enable_n = 1, action_select_hi = 1, action_select_lo = 1;
  logic byte_select_1 = 0, byte_select_2 = 0, erase_locks = 0;
  logic [7:0] data_in = 8'h00;
  wire [7:0] data_out;
  wire data_oe, ready_busy, nvm_wr_valid, nvm_wr_ready, nvm_wr_eeprom, nvm_rd_eeprom;
  wire [23:0] nvm_wr_addr, nvm_rd_addr;
  wire [15:0] nvm_wr_data, nvm_rd_data;
  int n_errors = 0, check_count = 0;

  // Five nanosecond period.
  always #2.5 clk_sys = ~clk_sys;

  nvm_prog_port #(.PROG_CYCLES(16)) nvm_prog_port_inst (.clk_sys(clk_sys), .rst(rst),
    .load_strobe(load_strobe), .page_latch(page_latch), .write_n(write_n),
    .output_enable_n(output_enable_n), .action_select_hi(action_select_hi),
    .action_select_lo(action_select_lo), .byte_select_1(byte_select_1),
    .byte_select_2(byte_select_2), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .ready_busy(ready_busy), .erase_locks(erase_locks),
    .nvm_wr_valid(nvm_wr_valid), .nvm_wr_ready(nvm_wr_ready),
    .nvm_wr_eeprom(nvm_wr_eeprom), .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data),
    .nvm_rd_eeprom(nvm_rd_eeprom), .nvm_rd_addr(nvm_rd_addr), .nvm_rd_data(nvm_rd_data));

  nvm_array_model nvm_array_model_inst (.clk_sys(clk_sys), .rst(rst),
    .nvm_wr_valid(nvm_wr_valid), .nvm_wr_ready(nvm_wr_ready),
    .nvm_wr_eeprom(nvm_wr_eeprom), .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data),
    .nvm_rd_eeprom(nvm_rd_eeprom), .nvm_rd_addr(nvm_rd_addr), .nvm_rd_data(nvm_rd_data));

  // ********************************
  // Shared tasks
  // ********************************
  task check(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One strobe pulse; low for an edge afterwards so the next one is seen.
  task load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] d);
    @(posedge clk_sys);
    {action_select_hi, action_select_lo} <= act;
    {byte_select_2, byte_select_1} <= bs;
    data_in <= d;
    load_strobe <= 1'b1;
    @(posedge clk_sys);
    load_strobe <= 1'b0;
    @(posedge clk_sys);
  endtask

  task latch;
    @(posedge clk_sys);
    byte_select_1 <= 1'b1;
    page_latch <= 1'b1;
    @(posedge clk_sys);
    page_latch <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Write pulse, then a bounded wait for ready.
  task wr(input logic [1:0] bs);
    @(posedge clk_sys);
    {byte_select_2, byte_select_1} <= bs;
    @(posedge clk_sys);
    write_n <= 1'b0;
    @(posedge clk_sys);
    write_n <= 1'b1;
    @(posedge clk_sys);
    #1 check(ready_busy, 1'b0);
    for (int i = 0; i < 2000 && ready_busy !== 1'b1; i++) @(posedge clk_sys);
    #1 check(ready_busy, 1'b1);
  endtask

  task rd(input logic [1:0] bs, input logic [7:0] exp);
    @(posedge clk_sys);
    {byte_select_2, byte_select_1} <= bs;
    output_enable_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 check(data_out, exp);
    check(data_oe, 1'b1);
    @(posedge clk_sys);
    output_enable_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // A run of well under 20000 cycles is expected.
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    final_report;
  end

  // ********************************
  // Tests
  // ********************************
  initial begin
    logic [7:0] fz [0:2];
    logic [7:0] sg [0:2];
    fz = '{8'hE1, 8'hD2, 8'hB4};
    sg = '{8'h5A, 8'hA5, 8'h3C};
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1 check(ready_busy, 1'b1);
    check(data_oe, 1'b0);
    $display("test reset done");
    // Two flash words in a page selected by address bits 23 to 7.
    load(`NVM_ACT_CMD, 2'b00, `NVM_CMD_WR_FLASH);
    load(`NVM_ACT_ADDR, `NVM_BS_EXT, 8'h00);
    load(`NVM_ACT_ADDR, `NVM_BS_HIGH, 8'h01);
    for (int i = 0; i < 2; i++) begin
      load(`NVM_ACT_ADDR, `NVM_BS_LOW, 8'h80 + i);
      load(`NVM_ACT_DATA, 2'b00, 8'h50 + i);
      load(`NVM_ACT_DATA, 2'b01, 8'hA0 + i);
      latch;
    end
    wr(`NVM_BS_LOW);
    check(nvm_array_model_inst.fl[8'h80], 16'hA050);
    check(nvm_array_model_inst.last_addr, 24'h00_0181);
    // Only the command and low byte are reloaded for read-back.
    load(`NVM_ACT_CMD, 2'b00, `NVM_CMD_RD_FLASH);
    for (int i = 0; i < 2; i++) begin
      load(`NVM_ACT_ADDR, `NVM_BS_LOW, 8'h80 + i);
      rd(2'b00, 8'h50 + i);
      rd(2'b01, 8'hA0 + i);
    end
    $display("test flash done");
    load(`NVM_ACT_CMD, 2'b00, `NVM_CMD_WR_EE);
    load(`NVM_ACT_ADDR, `NVM_BS_HIGH, 8'h00);
    load(`NVM_ACT_ADDR, `NVM_BS_LOW, 8'h05);
    load(`NVM_ACT_DATA, 2'b00, 8'h3C);
    latch;
    wr(`NVM_BS_LOW);
    check(nvm_array_model_inst.last_addr, 24'h00_0005);
    load(`NVM_ACT_CMD, 2'b00, `NVM_CMD_RD_EE);
    rd(2'b00, 8'h3C);
    $display("test eeprom done");
    // Each fuse byte gets its own pattern so a wrong select shows.
    load(`NVM_ACT_CMD, 2'b00, `NVM_CMD_WR_FUSE);
    for (int k = 0; k < 3; k++) begin
      load(`NVM_ACT_DATA, 2'b00, fz[k]);
      wr(k[1:0]);
    end
    load(`NVM_ACT_CMD, 2'b00, `NVM_CMD_RD_FUSE);
    rd(`NVM_BS_LOW, fz[0]);
    rd(`NVM_BS_TOP, fz[1]);
    rd(`NVM_BS_EXT, fz[2]);
    // Lock mode 3, then an attempt on the boot bits and an erase attempt.
    load(`NVM_ACT_CMD, 2'b00, `NVM_CMD_WR_LOCK);
    load(`NVM_ACT_DATA, 2'b00, 8'hFC);
    wr(2'b00);
    load(`NVM_ACT_DATA, 2'b00, 8'hC3);
    wr(2'b00);
    load(`NVM_ACT_DATA, 2'b00, 8'hFF);
    wr(2'b00);
    load(`NVM_ACT_CMD, 2'b00, `NVM_CMD_RD_FUSE);
    rd(`NVM_BS_HIGH, 8'hFC);
    @(posedge clk_sys);
    erase_locks <= 1'b1;
    @(posedge clk_sys);
    erase_locks <= 1'b0;
    rd(`NVM_BS_HIGH, 8'hFF);
    $display("test fuse and lock done");
    load(`NVM_ACT_CMD, 2'b00, `NVM_CMD_RD_SIG);
    for (int k = 0; k < 3; k++) begin
      load(`NVM_ACT_ADDR, `NVM_BS_LOW, k[7:0]);
      rd(2'b00, sg[k]);
    end
    load(`NVM_ACT_ADDR, `NVM_BS_LOW, 8'h00);
    rd(2'b01, 8'h80);
    load(`NVM_ACT_IDLE, 2'b00, `NVM_CMD_NOP);
    rd(2'b00, sg[0]);
    $display("test signature done");
    // Fill the buffer past its depth, then flush it with the no-op command.
    load(`NVM_ACT_CMD, 2'b00, `NVM_CMD_WR_FLASH);
    repeat (32) latch;
    #1 check(ready_busy, 1'b1);
    latch;
    #1 check(ready_busy, 1'b0);
    load(`NVM_ACT_CMD, 2'b00, `NVM_CMD_NOP);
    repeat (2) @(posedge clk_sys);
    #1 check(ready_busy, 1'b1);
    rd(2'b00, 8'hFF);
    load(`NVM_ACT_CMD, 2'b00, `NVM_CMD_WR_FLASH);
    wr(`NVM_BS_LOW);
    check(nvm_array_model_inst.wr_count, 3);
    $display("test buffer done");
    final_report;
  end
endmodule

bind nvm_prog_port nvm_prog_port_props #(.PROG_CYCLES(PROG_CYCLES)) nvm_prog_port_props_inst (
  .clk_sys(clk_sys), .rst(rst), .write_n(write_n), .output_enable_n(output_enable_n),
  .data_oe(data_oe), .ready_busy(ready_busy), .nvm_wr_valid(nvm_wr_valid),
  .nvm_wr_ready(nvm_wr_ready), .nvm_wr_eeprom(nvm_wr_eeprom),
  .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data));
`default_nettype wire
